/* File: src/drive_status_command_regs.sv */
// Drive status words and network command word register bank
`timescale 1ns/100ps
`default_nettype none
module drive_status_command_regs #(
   parameter int ANALOG_W = drive_regs_pkg::ANALOG_W_DEF
) (
   input wire logic core_clk_in, // 125 MHz core clock
   input wire logic arst_n_in, // Asynchronous reset, active low
   // Word access port from the network front end
   input wire logic [drive_regs_pkg::ADDR_W-1:0] reg_addr_in, // Word address
   input wire logic reg_rd_in, // Read strobe
   input wire logic reg_wr_in, // Write strobe
   input wire logic [drive_regs_pkg::WORD_W-1:0] reg_wdata_in, // Write data
   output logic [drive_regs_pkg::WORD_W-1:0] reg_rdata_out, // Read data
   output logic reg_ack_out, // Access done
   output logic reg_err_out, // Access refused
   // Trip condition pins, asynchronous
   input wire logic excess_current_trip_one_in, // Excess current one
   input wire logic high_bus_voltage_trip_in, // High bus voltage
   input wire logic outside_fault_trip_in, // Outside fault input
   input wire logic emergency_stop_trip_in, // Emergency stop terminal
   input wire logic supply_sag_trip_in, // Supply sag
   input wire logic earth_leakage_trip_in, // Earth leakage
   input wire logic drive_heatsink_trip_in, // Heatsink over-temperature
   input wire logic motor_thermal_trip_in, // Motor thermal
   input wire logic motor_load_excess_trip_in, // Motor load excess
   input wire logic hardware_selftest_fault_in, // Self-test fault
   input wire logic excess_current_trip_two_in, // Excess current two
   input wire logic card_fault_trip_in, // Add-on card fault
   input wire logic phase_loss_trip_in, // Output phase loss
   input wire logic drive_load_trip_in, // Drive load capacity exceeded
   // Terminal pins, asynchronous
   input wire logic [drive_regs_pkg::DIN_W-1:0] digital_input_in, // Inputs
   input wire logic [drive_regs_pkg::RELAY_W-1:0] relay_output_in, // Relays
   input wire logic fault_relay_contact_in, // Fault relay contact
   // Drive logic values, same clock
   input wire logic [ANALOG_W-1:0] main_voltage_input_in, // Voltage input
   input wire logic [ANALOG_W-1:0] signed_voltage_input_in, // Signed input
   input wire logic [ANALOG_W-1:0] current_input_in, // Current input
   input wire logic [drive_regs_pkg::WORD_W-1:0] shaft_speed_in, // Speed
   input wire logic [drive_regs_pkg::SRC_W-1:0] run_source_in, // Run source
   // Command pulses to the drive sequencer
   output logic stop_cmd_out, // Stop pulse
   output logic fwd_run_cmd_out, // Forward run pulse
   output logic rev_run_cmd_out, // Reverse run pulse
   output logic fault_reset_cmd_out, // Fault reset pulse
   output logic estop_cmd_out, // Emergency stop pulse
   output logic trip_latched_out // Any trip latched
);
   import drive_regs_pkg::*;

   localparam int SYNC_W = WORD_W + DIN_W + RELAY_W + 1;
   localparam int PAD_W = WORD_W - ANALOG_W;

   logic [WORD_W-1:0] trip_pin_w;
   logic [SYNC_W-1:0] sync_q;
   logic [WORD_W-1:0] trip_q;
   logic [DIN_W-1:0] din_q;
   logic [RELAY_W-1:0] relay_q;
   logic fault_q;
   logic [WORD_W-1:0] trip_set_w;
   logic [WORD_W-1:0] trip_r;
   logic [CMD_BITS-1:0] cmd_r;
   logic [CMD_BITS-1:0] cmd_rise_w;
   logic [CMD_BITS-1:0] pulse_r;
   logic [WORD_W-1:0] cmd_word_w;
   logic [WORD_W-1:0] dout_word_w;
   logic [WORD_W-1:0] rd_word_w;
   logic mapped_w;
   logic is_cmd_w;
   logic acc_w;
   logic acc_bad_w;
   logic cmd_wr_w;

   // R01: R02: R03: R04: R05: R06: R07: trip bit order
   // Gather trip pins into word order; spare bits stay low
   always_comb
   begin
      trip_pin_w = WORD_ZERO;
      trip_pin_w[TRIP_EXC_CUR1_BIT] = excess_current_trip_one_in;
      trip_pin_w[TRIP_BUS_HIGH_BIT] = high_bus_voltage_trip_in;
      trip_pin_w[TRIP_EXT_FAULT_BIT] = outside_fault_trip_in;
      trip_pin_w[TRIP_ESTOP_BIT] = emergency_stop_trip_in;
      trip_pin_w[TRIP_SUPPLY_SAG_BIT] = supply_sag_trip_in;
      trip_pin_w[TRIP_EARTH_BIT] = earth_leakage_trip_in;
      trip_pin_w[TRIP_HEATSINK_BIT] = drive_heatsink_trip_in;
      trip_pin_w[TRIP_MOTOR_THERM_BIT] = motor_thermal_trip_in;
      trip_pin_w[TRIP_MOTOR_LOAD_BIT] = motor_load_excess_trip_in;
      trip_pin_w[TRIP_SELFTEST_BIT] = hardware_selftest_fault_in;
      trip_pin_w[TRIP_EXC_CUR2_BIT] = excess_current_trip_two_in;
      trip_pin_w[TRIP_CARD_BIT] = card_fault_trip_in;
      trip_pin_w[TRIP_PHASE_LOSS_BIT] = phase_loss_trip_in;
      trip_pin_w[TRIP_DRIVE_LOAD_BIT] = drive_load_trip_in;
   end

   // All pins share one synchroniser so a word is filtered uniformly
   pin_sync3 #(
      .W(SYNC_W)
   ) u_pin_sync (
      .clk_in(core_clk_in),
      .arst_n_in(arst_n_in),
      .d_in({trip_pin_w, digital_input_in, relay_output_in,
             fault_relay_contact_in}),
      .q_out(sync_q)
   );

   assign {trip_q, din_q, relay_q, fault_q} = sync_q;

   // R14: network stop latches
   // A network emergency stop also latches the stop trip bit
   always_comb
   begin
      trip_set_w = trip_q & TRIP_USED_MASK;
      trip_set_w[TRIP_ESTOP_BIT] = trip_q[TRIP_ESTOP_BIT] |
                                   pulse_r[CMD_ESTOP_BIT];
   end

   // R18: latch and clear
   // Set wins over the fault reset, so a trip present at reset stays
   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         trip_r <= WORD_ZERO;
      else if (pulse_r[CMD_FRST_BIT])
         trip_r <= trip_set_w;
      else
         trip_r <= trip_r | trip_set_w;
   end

   assign trip_latched_out = |trip_r;

   // Access decode
   assign acc_w = reg_rd_in | reg_wr_in;
   assign is_cmd_w = (reg_addr_in == ADDR_CMD);
   assign acc_bad_w = (reg_rd_in & reg_wr_in) | (acc_w & !mapped_w) |
                      (reg_wr_in & !is_cmd_w);
   assign cmd_wr_w = reg_wr_in & !reg_rd_in & is_cmd_w;

   // R17: edge against stored
   assign cmd_rise_w = reg_wdata_in[CMD_BITS-1:0] & ~cmd_r;

   // R16: volatile command
   // Command bits live only in flops; reset returns them to zero
   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         cmd_r <= CMD_RESET;
      else if (cmd_wr_w)
         cmd_r <= reg_wdata_in[CMD_BITS-1:0];
   end

   // R11: R12: R13: rising pulses
   // One pulse per 0-to-1 write, in the cycle after the write
   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         pulse_r <= CMD_RESET;
      else if (cmd_wr_w)
         pulse_r <= cmd_rise_w;
      else
         pulse_r <= CMD_RESET;
   end

   assign stop_cmd_out = pulse_r[CMD_STOP_BIT];
   assign fwd_run_cmd_out = pulse_r[CMD_FWD_BIT];
   assign rev_run_cmd_out = pulse_r[CMD_REV_BIT];
   assign fault_reset_cmd_out = pulse_r[CMD_FRST_BIT];
   assign estop_cmd_out = pulse_r[CMD_ESTOP_BIT];

   // R15: run source readback
   // Frequency and network error fields are not kept here; they read 0
   always_comb
   begin
      cmd_word_w = WORD_ZERO;
      cmd_word_w[CMD_BITS-1:0] = cmd_r;
      cmd_word_w[CMD_SRC_MSB:CMD_SRC_LSB] = run_source_in;
   end

   // R09: output word layout
   always_comb
   begin
      dout_word_w = WORD_ZERO;
      dout_word_w[RELAY_W-1:0] = relay_q;
      dout_word_w[FAULT_RELAY_BIT] = fault_q;
   end

   // R01: R08: read mux
   // Analog samples are left justified so full scale reads 0xffc0
   always_comb
   begin
      rd_word_w = WORD_ZERO;
      mapped_w = 1'b1;
      case (reg_addr_in)
         ADDR_CMD: rd_word_w = cmd_word_w;
         ADDR_TRIP: rd_word_w = trip_r;
         ADDR_DIN: rd_word_w[DIN_W-1:0] = din_q;
         ADDR_DOUT: rd_word_w = dout_word_w;
         ADDR_MAIN_V: rd_word_w = {main_voltage_input_in, {PAD_W{1'b0}}};
         ADDR_SIGNED_V: rd_word_w = {signed_voltage_input_in, {PAD_W{1'b0}}};
         ADDR_CURRENT: rd_word_w = {current_input_in, {PAD_W{1'b0}}};
         ADDR_SPEED: rd_word_w = shaft_speed_in;
         default: mapped_w = 1'b0;
      endcase
   end

   // Answer one cycle after the strobe; refused reads return zero
   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         reg_ack_out <= 1'b0;
         reg_err_out <= 1'b0;
         reg_rdata_out <= WORD_ZERO;
      end
      else
      begin
         reg_ack_out <= acc_w & !acc_bad_w;
         reg_err_out <= acc_bad_w;
         if (reg_rd_in)
            reg_rdata_out <= acc_bad_w ? WORD_ZERO : rd_word_w;
      end
   end

   // Helper for checks: trips that were set one cycle ago
   logic [WORD_W-1:0] trip_seen_r;
   logic [WORD_W-1:0] lost_w;
   logic rd_ok_w;

   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         trip_seen_r <= WORD_ZERO;
      else
         trip_seen_r <= trip_set_w;
   end

   assign lost_w = trip_seen_r & ~trip_r;
   assign rd_ok_w = reg_rd_in & !reg_wr_in;

   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!arst_n_in);

   property p_trip_low;
      !(lost_w[TRIP_EXC_CUR1_BIT] || lost_w[TRIP_BUS_HIGH_BIT] ||
        lost_w[TRIP_EXT_FAULT_BIT]);
   endproperty
   a_trip_low: assert property (p_trip_low) // R01
      else $error("low trip bit not latched");

   property p_trip_stop_sag;
      !(lost_w[TRIP_ESTOP_BIT] || lost_w[TRIP_SUPPLY_SAG_BIT]) &&
      !trip_r[TRIP_SPARE_A_BIT];
   endproperty
   a_trip_stop_sag: assert property (p_trip_stop_sag) // R02
      else $error("stop or sag trip wrong");

   property p_trip_earth_heat;
      !(lost_w[TRIP_EARTH_BIT] || lost_w[TRIP_HEATSINK_BIT]);
   endproperty
   a_trip_earth_heat: assert property (p_trip_earth_heat) // R03
      else $error("earth or heatsink trip not latched");

   property p_trip_motor;
      !(lost_w[TRIP_MOTOR_THERM_BIT] || lost_w[TRIP_MOTOR_LOAD_BIT]);
   endproperty
   a_trip_motor: assert property (p_trip_motor) // R04
      else $error("motor trip not latched");

   property p_trip_self_cur2;
      !(lost_w[TRIP_SELFTEST_BIT] || lost_w[TRIP_EXC_CUR2_BIT]) &&
      !trip_r[TRIP_SPARE_B_BIT];
   endproperty
   a_trip_self_cur2: assert property (p_trip_self_cur2) // R05
      else $error("self-test or current two trip wrong");

   property p_trip_card_phase;
      !(lost_w[TRIP_CARD_BIT] || lost_w[TRIP_PHASE_LOSS_BIT]);
   endproperty
   a_trip_card_phase: assert property (p_trip_card_phase) // R06
      else $error("card or phase trip not latched");

   property p_trip_drive_load;
      trip_q[TRIP_DRIVE_LOAD_BIT] |=> trip_r[TRIP_DRIVE_LOAD_BIT] &&
         trip_latched_out;
   endproperty
   a_trip_drive_load: assert property (p_trip_drive_load) // R07
      else $error("drive load trip not latched");

   property p_din_read;
      rd_ok_w && reg_addr_in == ADDR_DIN |=> reg_ack_out &&
         reg_rdata_out == {{(WORD_W-DIN_W){1'b0}}, $past(din_q)};
   endproperty
   a_din_read: assert property (p_din_read) // R08
      else $error("input word read wrong");

   property p_dout_read;
      rd_ok_w && reg_addr_in == ADDR_DOUT |=> reg_ack_out &&
         reg_rdata_out == $past(dout_word_w) &&
         reg_rdata_out[FAULT_RELAY_BIT-1:RELAY_W] == '0;
   endproperty
   a_dout_read: assert property (p_dout_read) // R09
      else $error("output word read wrong");

   property p_fwd_rise;
      cmd_wr_w && reg_wdata_in[CMD_FWD_BIT] && !cmd_r[CMD_FWD_BIT] |=>
         fwd_run_cmd_out ##1 !fwd_run_cmd_out;
   endproperty
   a_fwd_rise: assert property (p_fwd_rise) // R11
      else $error("forward run pulse missing");

   property p_rev_rise;
      cmd_wr_w && reg_wdata_in[CMD_REV_BIT] && !cmd_r[CMD_REV_BIT] |=>
         rev_run_cmd_out;
   endproperty
   a_rev_rise: assert property (p_rev_rise) // R12
      else $error("reverse run pulse missing");

   property p_frst_clear;
      cmd_wr_w && reg_wdata_in[CMD_FRST_BIT] && !cmd_r[CMD_FRST_BIT] |=>
         fault_reset_cmd_out ##1 (trip_r & ~trip_seen_r) == WORD_ZERO;
   endproperty
   a_frst_clear: assert property (p_frst_clear) // R13
      else $error("fault reset did not clear trips");

   property p_estop;
      cmd_wr_w && reg_wdata_in[CMD_ESTOP_BIT] && !cmd_r[CMD_ESTOP_BIT] |=>
         estop_cmd_out ##1 trip_r[TRIP_ESTOP_BIT];
   endproperty
   a_estop: assert property (p_estop) // R14
      else $error("emergency stop not issued");

   property p_src_read;
      rd_ok_w && is_cmd_w |=>
         reg_rdata_out[CMD_SRC_MSB:CMD_SRC_LSB] == $past(run_source_in);
   endproperty
   a_src_read: assert property (p_src_read) // R15
      else $error("run source readback wrong");

   property p_cmd_store;
      cmd_wr_w |=> cmd_r == $past(reg_wdata_in[CMD_BITS-1:0]);
   endproperty
   a_cmd_store: assert property (p_cmd_store) // R16
      else $error("command write not applied");

   property p_no_repeat;
      cmd_wr_w |=> pulse_r == ($past(reg_wdata_in[CMD_BITS-1:0]) &
         ~$past(cmd_r));
   endproperty
   a_no_repeat: assert property (p_no_repeat) // R17
      else $error("command pulse not on rising edge only");

   property p_trip_hold;
      !pulse_r[CMD_FRST_BIT] && trip_r != WORD_ZERO |=>
         (trip_r & $past(trip_r)) == $past(trip_r);
   endproperty
   a_trip_hold: assert property (p_trip_hold) // R18
      else $error("trip bit dropped without fault reset");
endmodule
`default_nettype wire

/* File: include/drive_regs_pkg.sv */
// Constants and register map of the drive status and command word bank
// Operation
// R01: Trip word bits 0-2: excess current one, high bus voltage, outside fault.
// R02: Trip word bit 3 emergency stop, bit 4 supply sag, bit 5 unused.
// R03: Trip word bit 6 earth leakage, bit 7 drive heatsink over-temperature.
// R04: Trip word bit 8 motor thermal, bit 9 motor load excess.
// R05: Trip word bit 10 self-test fault, bit 12 excess current two, 11 unused.
// R06: Trip word bit 13 add-on card fault, bit 14 output phase loss.
// R07: Trip word bit 15 drive load capacity exceeded.
// R08: Input word bits 0-7 show digital input terminals one to eight.
// R09: Output word: relays one-four on bits 0-3, fault relay bit 7.
// R10: Master issues stop by writing 1 over 0 in command bit 0.
// R11: Rising command bit 1 starts forward rotation.
// R12: Rising command bit 2 starts reverse rotation.
// R13: Rising command bit 3 clears the latched trip condition.
// R14: Rising command bit 4 performs an emergency stop.
// R15: Command bits 6-7 read the active run source, read only.
// R16: Command writes act at once, are volatile, revert at reset.
// R17: Rising edge found against stored bit; 1 over 1 issues nothing.
// R18: Trip bits hold while latched and clear on accepted fault reset.
package drive_regs_pkg;
   localparam int WORD_W = 16;
   localparam int ADDR_W = 16;
   localparam logic [ADDR_W-1:0] ADDR_CMD = 16'h0006;
   localparam logic [ADDR_W-1:0] ADDR_TRIP = 16'h000f;
   localparam logic [ADDR_W-1:0] ADDR_DIN = 16'h0010;
   localparam logic [ADDR_W-1:0] ADDR_DOUT = 16'h0011;
   localparam logic [ADDR_W-1:0] ADDR_MAIN_V = 16'h0012;
   localparam logic [ADDR_W-1:0] ADDR_SIGNED_V = 16'h0013;
   localparam logic [ADDR_W-1:0] ADDR_CURRENT = 16'h0014;
   localparam logic [ADDR_W-1:0] ADDR_SPEED = 16'h0015;
   // Command word fields
   localparam int CMD_STOP_BIT = 0;
   localparam int CMD_FWD_BIT = 1;
   localparam int CMD_REV_BIT = 2;
   localparam int CMD_FRST_BIT = 3;
   localparam int CMD_ESTOP_BIT = 4;
   localparam int CMD_BITS = 5;
   localparam int CMD_SRC_LSB = 6;
   localparam int CMD_SRC_MSB = 7;
   localparam int SRC_W = 2;
   localparam logic [CMD_BITS-1:0] CMD_RESET = 5'h00;
   // Trip word fields
   localparam int TRIP_EXC_CUR1_BIT = 0;
   localparam int TRIP_BUS_HIGH_BIT = 1;
   localparam int TRIP_EXT_FAULT_BIT = 2;
   localparam int TRIP_ESTOP_BIT = 3;
   localparam int TRIP_SUPPLY_SAG_BIT = 4;
   localparam int TRIP_SPARE_A_BIT = 5;
   localparam int TRIP_EARTH_BIT = 6;
   localparam int TRIP_HEATSINK_BIT = 7;
   localparam int TRIP_MOTOR_THERM_BIT = 8;
   localparam int TRIP_MOTOR_LOAD_BIT = 9;
   localparam int TRIP_SELFTEST_BIT = 10;
   localparam int TRIP_SPARE_B_BIT = 11;
   localparam int TRIP_EXC_CUR2_BIT = 12;
   localparam int TRIP_CARD_BIT = 13;
   localparam int TRIP_PHASE_LOSS_BIT = 14;
   localparam int TRIP_DRIVE_LOAD_BIT = 15;
   localparam logic [WORD_W-1:0] TRIP_USED_MASK = 16'hf7df;
   localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
   // Terminal word fields
   localparam int DIN_W = 8;
   localparam int RELAY_W = 4;
   localparam int FAULT_RELAY_BIT = 7;
   // Analog sample width, left justified so full scale reads 0xffc0
   localparam int ANALOG_W_DEF = 10;
endpackage

/* File: src/pin_sync3.sv */
// Three-stage pin synchroniser that passes a change once stages agree
`timescale 1ns/100ps
`default_nettype none
module pin_sync3 #(
   parameter int W = 1
) (
   input wire logic clk_in, // Core clock
   input wire logic arst_n_in, // Asynchronous reset, active low
   input wire logic [W-1:0] d_in, // Raw pin levels
   output logic [W-1:0] q_out // Filtered levels
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;

   // Stage one feeds stage two only; a bit moves when two and three agree
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         q_out <= '0;
      end
      else
      begin
         s1_r <= d_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         for (int i = 0; i < W; i++)
         begin
            if (s2_r[i] == s3_r[i])
               q_out[i] <= s3_r[i];
         end
      end
   end
endmodule
`default_nettype wire

/* File: tb/net_master.sv */
// Network master model that polls and commands the register bank
`timescale 1ns/100ps
`default_nettype none
module net_master (
   input wire logic clk_in, // Core clock
   input wire logic [15:0] rdata_in, // Read data
   input wire logic ack_in, // Access done
   input wire logic err_in, // Access refused
   output logic [15:0] addr_out, // Word address
   output logic rd_out, // Read strobe
   output logic wr_out, // Write strobe
   output logic [15:0] wdata_out, // Write data
   output logic hang_out // No answer came
);
   logic [15:0] last_rdata;
   logic last_err;
   // Idle bus from time zero
   initial
   begin
      addr_out = 16'h0000;
      rd_out = 1'b0;
      wr_out = 1'b0;
      wdata_out = 16'h0000;
      hang_out = 1'b0;
   end
   // One strobe cycle only, since each high cycle counts as an access
   task automatic access(input logic w, input logic [15:0] a,
      input logic [15:0] d);
      int n;
      logic got;
      got = 1'b0;
      @(posedge clk_in);
      addr_out <= a;
      rd_out <= !w;
      wr_out <= w;
      wdata_out <= d;
      @(posedge clk_in);
      rd_out <= 1'b0;
      wr_out <= 1'b0;
      // Released lines flip so stale values cannot pass for held ones
      addr_out <= ~a;
      wdata_out <= ~d;
      for (n = 0; n < 4 && !got; n++)
      begin
         #1;
         if (ack_in || err_in)
            got = 1'b1;
         else
            @(posedge clk_in);
      end
      last_rdata = rdata_in;
      last_err = err_in;
      if (!got)
         hang_out = 1'b1;
   endtask
   // clear the bit, then raise it
   task automatic issue(input logic [15:0] d);
      access(1'b1, 16'h0006, 16'h0000);
      access(1'b1, 16'h0006, d);
   endtask
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the drive status and command bank
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import drive_regs_pkg::*;
   typedef struct packed {
      logic [1:0] src;
      logic [15:0] wdata;
      logic [4:0] pulses;
      logic [15:0] rb;
   } cmd_row_s;
   logic clk;
   logic arst_n;
   logic [15:0] addr;
   logic rd;
   logic wr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic ack;
   logic err;
   logic hang;
   logic [15:0] trip_pins;
   logic [7:0] din;
   logic [3:0] relay;
   logic frelay;
   logic [9:0] mainv;
   logic [9:0] signv;
   logic [9:0] curr;
   logic [15:0] speed;
   logic [1:0] src;
   logic [4:0] pulses;
   logic trip_flag;
   logic [15:0] exp;
   int failures;
   int num_checks;
   // Writes in order; stored bits carry over from row to row
   cmd_row_s rows[11] = '{
      '{2'h0, 16'h0000, 5'h00, 16'h0000}, '{2'h1, 16'h0001, 5'h01, 16'h0041},
      '{2'h1, 16'h0001, 5'h00, 16'h0041}, '{2'h2, 16'h0002, 5'h02, 16'h0082},
      '{2'h2, 16'h0006, 5'h04, 16'h0086}, '{2'h3, 16'h0000, 5'h00, 16'h00c0},
      '{2'h3, 16'h0008, 5'h08, 16'h00c8}, '{2'h0, 16'h0018, 5'h10, 16'h0018},
      '{2'h0, 16'h001f, 5'h07, 16'h001f}, '{2'h3, 16'hffff, 5'h00, 16'h00df},
      '{2'h1, 16'h0000, 5'h00, 16'h0040}};
   net_master u_master (.clk_in(clk), .rdata_in(rdata), .ack_in(ack),
      .err_in(err), .addr_out(addr), .rd_out(rd), .wr_out(wr),
      .wdata_out(wdata), .hang_out(hang));
   drive_status_command_regs u_dut (.core_clk_in(clk), .arst_n_in(arst_n),
      .reg_addr_in(addr), .reg_rd_in(rd), .reg_wr_in(wr),
      .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_ack_out(ack),
      .reg_err_out(err), .excess_current_trip_one_in(trip_pins[0]),
      .high_bus_voltage_trip_in(trip_pins[1]),
      .outside_fault_trip_in(trip_pins[2]),
      .emergency_stop_trip_in(trip_pins[3]),
      .supply_sag_trip_in(trip_pins[4]),
      .earth_leakage_trip_in(trip_pins[6]),
      .drive_heatsink_trip_in(trip_pins[7]),
      .motor_thermal_trip_in(trip_pins[8]),
      .motor_load_excess_trip_in(trip_pins[9]),
      .hardware_selftest_fault_in(trip_pins[10]),
      .excess_current_trip_two_in(trip_pins[12]),
      .card_fault_trip_in(trip_pins[13]), .phase_loss_trip_in(trip_pins[14]),
      .drive_load_trip_in(trip_pins[15]), .digital_input_in(din),
      .relay_output_in(relay), .fault_relay_contact_in(frelay),
      .main_voltage_input_in(mainv), .signed_voltage_input_in(signv),
      .current_input_in(curr), .shaft_speed_in(speed), .run_source_in(src),
      .stop_cmd_out(pulses[0]), .fwd_run_cmd_out(pulses[1]),
      .rev_run_cmd_out(pulses[2]), .fault_reset_cmd_out(pulses[3]),
      .estop_cmd_out(pulses[4]), .trip_latched_out(trip_flag));
   // Free-running 125 MHz clock
   initial
      clk = 1'b0;
   always #4 clk = ~clk;
   task automatic check_word(input string what, input logic [15:0] e,
      input logic [15:0] g);
      num_checks++;
      if (g !== e)
      begin
         failures++;
         $display("FAIL %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic check_bit(input string what, input logic e, input logic g);
      num_checks++;
      if (g !== e)
      begin
         failures++;
         $display("FAIL %s expected %b seen %b", what, e, g);
      end
   endtask
   task automatic read_chk(input string what, input logic [15:0] a,
      input logic [15:0] e);
      u_master.access(1'b0, a, 16'h0000);
      check_word(what, e, u_master.last_rdata);
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // A silent bank cuts the run short
   always @(posedge hang)
   begin
      failures++;
      complete_run();
   end
   initial
   begin
      failures = 0;
      num_checks = 0;
      arst_n = 1'b0;
      trip_pins = 16'h0000;
      din = 8'h00;
      relay = 4'h0;
      frelay = 1'b0;
      mainv = 10'h000;
      signv = 10'h000;
      curr = 10'h000;
      speed = 16'h0000;
      src = 2'h0;
      wait_cyc(6);
      arst_n <= 1'b1;
      wait_cyc(4);
      check_word("pulses after reset", 16'h0000, {11'h0, pulses});
      check_bit("trip flag after reset", 1'b0, trip_flag);
      $display("test reset done");
      // Command rows: edges, repeats, all run sources
      foreach (rows[i])
      begin
         @(posedge clk);
         src <= rows[i].src;
         u_master.access(1'b1, ADDR_CMD, rows[i].wdata);
         check_word("pulses", {11'h0, rows[i].pulses}, {11'h0, pulses});
         read_chk("command word", ADDR_CMD, rows[i].rb);
      end
      $display("test command rows done");
      // Walk each trip pin, hold after release, clear by fault reset
      u_master.issue(16'h0008);
      for (int i = 0; i < 16; i++)
      begin
         @(posedge clk);
         trip_pins <= 16'h0001 << i;
         exp = (i == 5 || i == 11) ? 16'h0000 : 16'h0001 << i;
         wait_cyc(6);
         read_chk("trip word", ADDR_TRIP, exp);
         check_bit("trip flag", exp != 16'h0000, trip_flag);
         @(posedge clk);
         trip_pins <= 16'h0000;
         wait_cyc(6);
         read_chk("trip held", ADDR_TRIP, exp);
         u_master.issue(16'h0008);
         read_chk("trip cleared", ADDR_TRIP, 16'h0000);
      end
      // A trip still present at the reset stays set
      @(posedge clk);
      trip_pins <= 16'h0002;
      wait_cyc(6);
      u_master.issue(16'h0008);
      read_chk("trip present", ADDR_TRIP, 16'h0002);
      $display("test trip word done");
      // Terminal words with alternating patterns
      for (int k = 0; k < 2; k++)
      begin
         @(posedge clk);
         din <= k ? 8'h5a : 8'ha5;
         relay <= k ? 4'h6 : 4'h9;
         frelay <= !k;
         wait_cyc(6);
         read_chk("inputs", ADDR_DIN, k ? 16'h005a : 16'h00a5);
         read_chk("outputs", ADDR_DOUT, k ? 16'h0006 : 16'h0089);
      end
      $display("test terminals done");
      // Analog words are left justified
      @(posedge clk);
      mainv <= 10'h3ff;
      signv <= 10'h001;
      curr <= 10'h200;
      speed <= 16'h1234;
      wait_cyc(2);
      read_chk("main voltage", ADDR_MAIN_V, 16'hffc0);
      read_chk("signed voltage", ADDR_SIGNED_V, 16'h0040);
      read_chk("current", ADDR_CURRENT, 16'h8000);
      read_chk("speed", ADDR_SPEED, 16'h1234);
      $display("test analog done");
      // Refused accesses leave the words untouched
      u_master.access(1'b1, ADDR_TRIP, 16'h0000);
      check_bit("write ro refused", 1'b1, u_master.last_err);
      read_chk("trip after write", ADDR_TRIP, 16'h0002);
      u_master.access(1'b0, 16'h0007, 16'h0000);
      check_bit("unmapped refused", 1'b1, u_master.last_err);
      check_word("unmapped data", 16'h0000, u_master.last_rdata);
      $display("test refusals done");
      // Command bits are volatile: reset returns them to zero
      u_master.access(1'b1, ADDR_CMD, 16'h001f);
      // Network emergency stop also latches the stop trip bit
      read_chk("estop latched", ADDR_TRIP, 16'h000a);
      @(posedge clk);
      arst_n <= 1'b0;
      wait_cyc(2);
      arst_n <= 1'b1;
      wait_cyc(4);
      read_chk("command after reset", ADDR_CMD, 16'h0040);
      u_master.access(1'b1, ADDR_CMD, 16'h0001);
      check_word("stop after reset", 16'h0001, {11'h0, pulses});
      $display("test volatile command done");
      complete_run();
   end
endmodule
`default_nettype wire
